// file: hw/canmp_top.sv
// Summary of operation
// - pending flags set on success, irq or not
// - each object routes tx/rx irq independently
// - rx irq also for fifo/gateway storage
// - every irq request also sets pending bit
// - position [7:5] register, [4:0] bit
// - control field folds node pointer in
// - cpu write zero clears, one keeps
// - hardware set wins over cpu clear
// - index shows lowest set bit, combinational
// - pending registers drive no irq lines
// - store only while object valid
// - clearing valid aborts ongoing writes
// - acceptance win sets selected flag
// - store only if selected still set
// - receive allowed only with receive enable
// - receive enable sampled at filtering only
// - updating flag spans storage and flags
// - store id/ide/dlc, data only data frames
// - set new data, lost if already set
// - flags same for data and remote
`timescale 1ns/1ps
`default_nettype none
module canmp_top
	import canmp_pkg::*;
#(
	parameter int N_OBJ = NUM_OBJ
) (
	input  wire logic                 REF_CLK,
	input  wire logic                 RST_N,
	input  wire logic                 HSEL,
	input  wire logic [31:0]          HADDR,
	input  wire logic [1:0]           HTRANS,
	input  wire logic                 HWRITE,
	input  wire logic [2:0]           HSIZE,
	input  wire logic [31:0]          HWDATA,
	input  wire logic                 HREADY,
	output logic      [31:0]          HRDATA,
	output logic                      HREADYOUT,
	output logic                      HRESP,
	input  wire logic                 ACC_WIN,
	input  wire logic [7:0]           ACC_OBJ,
	input  wire logic [2:0]           ACC_NODE,
	output logic      [N_OBJ-1:0]     RX_ALLOWED,
	input  wire logic                 RX_DONE,
	input  wire logic [7:0]           RX_OBJ,
	input  wire logic [2:0]           RX_NODE,
	input  wire canmp_frame_t         RX_FRAME,
	input  wire logic                 TX_DONE,
	input  wire logic [7:0]           TX_OBJ,
	input  wire logic [2:0]           TX_NODE,
	output logic      [NUM_LINE-1:0]  IRQ_LINE
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [NUM_PND-1:0][31:0] pnd;
		logic [1:0]               fold;
		logic [N_OBJ-1:0][9:0]    octl;
		logic [N_OBJ-1:0][15:0]   optr;
		logic [N_OBJ-1:0][ID_W:0] oid;
		logic [N_OBJ-1:0][3:0]    olen;
		logic [N_OBJ-1:0][63:0]   odat;
		canmp_state_t             st;
		logic [7:0]               cur_obj;
		logic [2:0]               cur_node;
		canmp_frame_t             cur_frm;
		logic                     aph;
		logic                     awr;
		logic [11:0]              aadr;
		logic [31:0]              rdat;
		logic [NUM_LINE-1:0]      irq;
	} canmp_reg_t;

	canmp_reg_t s_ff;
	canmp_reg_t nxt_s;

	function automatic logic [5:0] lowest_set(input logic [31:0] v);
		logic [5:0] r;
		r = IDX_NONE;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = 6'(i);
			end
		end
		return r;
	endfunction

	// pending position with optional node fold, wraps modulo 256
	function automatic logic [7:0] pend_pos(input logic [7:0] sel, input logic [2:0] node,
		input logic [3:0] line, input logic [1:0] fold);
		logic [7:0] add;
		add = 8'h00;
		if (fold == FOLD_NODE) begin
			add = {node, 5'h00};
		end else if (fold != FOLD_NONE) begin
			add = {1'b0, line[2:0], 4'h0};
		end
		return sel + add;
	endfunction

	logic [NUM_PND-1:0][5:0] idx;
	logic                    acc_go;
	logic                    wr_go;
	logic [11:0]             rel;
	logic [7:0]              sel_obj;
	logic                    val_clr;

	always_comb begin
		for (int p = 0; p < NUM_PND; p++) begin
			idx[p] = lowest_set(s_ff.pnd[p]);
		end
		for (int o = 0; o < N_OBJ; o++) begin
			RX_ALLOWED[o] = s_ff.octl[o][CB_VALID] & s_ff.octl[o][CB_RECEIVE_ALLOW];
		end
	end

	assign acc_go = HSEL & HREADY & HTRANS[1];
	assign wr_go  = s_ff.aph & s_ff.awr;
	assign rel    = s_ff.aadr - OBJ_BASE;
	assign sel_obj = 8'(rel[11:5]);
	// cpu clearing valid of the object under storage aborts it in that same cycle
	assign val_clr = wr_go && s_ff.aadr >= OBJ_BASE && sel_obj == s_ff.cur_obj
		&& rel[4:0] == OFS_OCTL && !HWDATA[CB_VALID];

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic [7:0]  pos;
		logic [9:0]  c;
		logic [2:0]  ln;
		logic [31:0] set_rx;
		logic [31:0] hw_set [NUM_PND];
		int          ob;
		logic [N_OBJ-1:0][9:0] oset;
		nxt_s = s_ff;
		oset = '0;
		pos = 8'h00;
		c = 10'h000;
		ln = 3'h0;
		set_rx = 32'h0;
		ob = 0;
		for (int p = 0; p < NUM_PND; p++) begin
			hw_set[p] = 32'h0;
		end
		nxt_s.irq = '0;
		// bus address phase capture
		nxt_s.aph = acc_go;
		if (acc_go) begin
			nxt_s.awr  = HWRITE;
			nxt_s.aadr = HADDR[11:0];
		end
		// transmit completion
		if (TX_DONE && TX_OBJ < 8'(N_OBJ)) begin
			ob = int'(TX_OBJ);
			nxt_s.octl[ob][CB_TXP] = 1'b1;
			oset[ob][CB_TXP] = 1'b1;
			if (s_ff.octl[ob][CB_TXIE]) begin
				ln = s_ff.optr[ob][PF_TXL +: 3];
				nxt_s.irq[ln] = 1'b1;
				pos = pend_pos(s_ff.optr[ob][PF_POS +: 8], TX_NODE,
					s_ff.optr[ob][PF_TXL +: 4], s_ff.fold);
				hw_set[pos[7:5]][pos[4:0]] = 1'b1;
			end
		end
		// receive storage sequence
		unique case (s_ff.st)
			CANMP_IDLE: begin
				// fifo/gateway deliveries come in here as well
				if (RX_DONE && RX_OBJ < 8'(N_OBJ)) begin
					ob = int'(RX_OBJ);
					// receive enable not looked at here, only at filtering
					if (s_ff.octl[ob][CB_VALID] && s_ff.octl[ob][CB_SEL]) begin
						nxt_s.st       = CANMP_STORE;
						nxt_s.cur_obj  = RX_OBJ;
						nxt_s.cur_node = RX_NODE;
						nxt_s.cur_frm  = RX_FRAME;
						nxt_s.octl[ob][CB_UPD] = 1'b1;
					end
				end
			end
			CANMP_STORE: begin
				ob = int'(s_ff.cur_obj);
				if (!s_ff.octl[ob][CB_VALID] || val_clr) begin
					nxt_s.st = CANMP_IDLE;
					nxt_s.octl[ob][CB_UPD] = 1'b0;
				end else begin
					nxt_s.oid[ob]  = {s_ff.cur_frm.ide, s_ff.cur_frm.id};
					nxt_s.olen[ob] = s_ff.cur_frm.dlc;
					if (!s_ff.cur_frm.remote) begin
						nxt_s.odat[ob] = s_ff.cur_frm.data;
					end
					nxt_s.st = CANMP_FLAGS;
				end
			end
			CANMP_FLAGS: begin
				ob = int'(s_ff.cur_obj);
				nxt_s.st = CANMP_IDLE;
				nxt_s.octl[ob][CB_UPD] = 1'b0;
				if (s_ff.octl[ob][CB_VALID] && !val_clr) begin
					// same path for remote and data frames
					c = s_ff.octl[ob];
					nxt_s.octl[ob][CB_NEW] = 1'b1;
					nxt_s.octl[ob][CB_LOST] = c[CB_LOST] | c[CB_NEW];
					nxt_s.octl[ob][CB_RXP] = 1'b1;
					oset[ob][CB_NEW] = 1'b1;
					oset[ob][CB_LOST] = c[CB_NEW];
					oset[ob][CB_RXP] = 1'b1;
					nxt_s.octl[ob][CB_SEL] = 1'b0;
					if (c[CB_RXIE]) begin
						ln = s_ff.optr[ob][PF_RXL +: 3];
						nxt_s.irq[ln] = 1'b1;
						pos = pend_pos(s_ff.optr[ob][PF_POS +: 8], s_ff.cur_node,
							s_ff.optr[ob][PF_RXL +: 4], s_ff.fold);
						set_rx[pos[4:0]] = 1'b1;
						hw_set[pos[7:5]] = hw_set[pos[7:5]] | set_rx;
					end
				end
			end
		endcase
		// after the flags stage, so a fresh win is not lost to its clear
		if (ACC_WIN && ACC_OBJ < 8'(N_OBJ)) begin
			nxt_s.octl[ACC_OBJ][CB_SEL] = 1'b1;
			oset[ACC_OBJ][CB_SEL] = 1'b1;
		end
		// cpu writes; hardware sets are applied after so they win
		if (wr_go) begin
			if (s_ff.aadr < IDX_BASE) begin
				nxt_s.pnd[s_ff.aadr[4:2]] = s_ff.pnd[s_ff.aadr[4:2]] & HWDATA;
			end else if (s_ff.aadr == CTRL_REG) begin
				nxt_s.fold = HWDATA[1:0];
			end else if (s_ff.aadr >= OBJ_BASE && sel_obj < 8'(N_OBJ)) begin
				ob = int'(sel_obj);
				unique case (rel[4:0])
					OFS_OCTL: begin
						// updating bit owned by hardware; pending bits also owned by hardware except clears
						c = HWDATA[9:0];
						c[CB_UPD] = nxt_s.octl[ob][CB_UPD];
						c[CB_TXP] = s_ff.octl[ob][CB_TXP] & HWDATA[CB_TXP];
						c[CB_RXP] = s_ff.octl[ob][CB_RXP] & HWDATA[CB_RXP];
						// hardware set this cycle wins, even over a clear of a set bit
						c = c | oset[ob];
						nxt_s.octl[ob] = c;
					end
					OFS_OPTR: nxt_s.optr[ob] = HWDATA[15:0];
					OFS_OID:  nxt_s.oid[ob]  = HWDATA[ID_W:0];
					OFS_OLEN: nxt_s.olen[ob] = HWDATA[3:0];
					OFS_ODLO: nxt_s.odat[ob][31:0]  = HWDATA;
					OFS_ODHI: nxt_s.odat[ob][63:32] = HWDATA;
					default: ;
				endcase
			end
		end
		for (int p = 0; p < NUM_PND; p++) begin
			nxt_s.pnd[p] = nxt_s.pnd[p] | hw_set[p];
		end
		// read data for the data phase
		nxt_s.rdat = 32'h0;
		if (acc_go && !HWRITE) begin
			if (HADDR[11:0] < IDX_BASE) begin
				nxt_s.rdat = s_ff.pnd[HADDR[4:2]];
			end else if (HADDR[11:0] < CTRL_REG) begin
				nxt_s.rdat = {26'h0, idx[HADDR[4:2]]};
			end else if (HADDR[11:0] == CTRL_REG) begin
				nxt_s.rdat = {30'h0, s_ff.fold};
			end else if (HADDR[11:0] >= OBJ_BASE && 8'(HADDR[11:5] - 7'h08) < 8'(N_OBJ)) begin
				ob = int'(HADDR[11:5] - 7'h08);
				unique case (HADDR[4:0])
					OFS_OCTL: nxt_s.rdat = {22'h0, s_ff.octl[ob]};
					OFS_OPTR: nxt_s.rdat = {16'h0, s_ff.optr[ob]};
					OFS_OID:  nxt_s.rdat = {{(31-ID_W){1'b0}}, s_ff.oid[ob]};
					OFS_OLEN: nxt_s.rdat = {28'h0, s_ff.olen[ob]};
					OFS_ODLO: nxt_s.rdat = s_ff.odat[ob][31:0];
					OFS_ODHI: nxt_s.rdat = s_ff.odat[ob][63:32];
					default:  nxt_s.rdat = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign HRDATA    = s_ff.rdat;
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	// lines come only from object routing, never from pending contents
	assign IRQ_LINE  = s_ff.irq;

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_rx_start;
		s_ff.st == CANMP_IDLE && nxt_s.st == CANMP_STORE;
	endsequence
	sequence s_rx_end;
		s_ff.st == CANMP_IDLE;
	endsequence

	a_upd_window: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_rx_start |=> s_ff.octl[s_ff.cur_obj][CB_UPD] ##[1:2] s_rx_end)
		else $error("update window wrong");
	a_no_store_unsel: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(s_ff.st == CANMP_IDLE && RX_DONE && RX_OBJ < 8'(N_OBJ) && !s_ff.octl[RX_OBJ][CB_SEL])
		|=> s_ff.st == CANMP_IDLE)
		else $error("stored unselected object");
	a_no_store_inval: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(s_ff.st == CANMP_IDLE && RX_DONE && RX_OBJ < 8'(N_OBJ) && !s_ff.octl[RX_OBJ][CB_VALID])
		|=> s_ff.st == CANMP_IDLE)
		else $error("stored invalid object");
	a_abort_inval: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(s_ff.st == CANMP_STORE && (!s_ff.octl[s_ff.cur_obj][CB_VALID] || val_clr))
		|=> s_ff.st == CANMP_IDLE && !s_ff.octl[$past(s_ff.cur_obj)][CB_UPD])
		else $error("no abort on invalid");
	a_new_set: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(s_ff.st == CANMP_FLAGS && s_ff.octl[s_ff.cur_obj][CB_VALID] && !val_clr)
		|=> s_ff.octl[$past(s_ff.cur_obj)][CB_NEW] && s_ff.octl[$past(s_ff.cur_obj)][CB_RXP])
		else $error("new data not set");
	a_lost_set: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(s_ff.st == CANMP_FLAGS && s_ff.octl[s_ff.cur_obj][CB_VALID] && s_ff.octl[s_ff.cur_obj][CB_NEW]
			&& !wr_go)
		|=> s_ff.octl[$past(s_ff.cur_obj)][CB_LOST])
		else $error("loss not flagged");
	a_sel_on_win: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(ACC_WIN && ACC_OBJ < 8'(N_OBJ) && !wr_go) |=> s_ff.octl[$past(ACC_OBJ)][CB_SEL])
		else $error("selected not set");
	a_idx_low: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(s_ff.pnd[0] != 32'h0) |-> s_ff.pnd[0][idx[0][4:0]]
			&& (s_ff.pnd[0] & ((32'h1 << idx[0][4:0]) - 32'h1)) == 32'h0)
		else $error("index wrong");
	a_tx_pend: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(TX_DONE && TX_OBJ < 8'(N_OBJ) && !wr_go) |=> s_ff.octl[$past(TX_OBJ)][CB_TXP])
		else $error("tx pending not set");
endmodule : canmp_top
`default_nettype wire

// file: hw/canmp_pkg.sv
package canmp_pkg;
	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int NUM_OBJ  = 4;
	localparam int NUM_PND  = 8;
	localparam int NUM_LINE = 8;
	localparam int ID_W     = 29;
	// ****************************************************************
	// register map, per-object block at OBJ_BASE + n*OBJ_STRIDE
	// ****************************************************************
	localparam logic [11:0] PND_BASE   = 12'h000;
	localparam logic [11:0] IDX_BASE   = 12'h020;
	localparam logic [11:0] CTRL_REG   = 12'h040;
	localparam logic [11:0] OBJ_BASE   = 12'h100;
	localparam logic [11:0] OBJ_STRIDE = 12'h020;
	localparam logic [4:0]  OFS_OCTL   = 5'h00;
	localparam logic [4:0]  OFS_OPTR   = 5'h04;
	localparam logic [4:0]  OFS_OID    = 5'h08;
	localparam logic [4:0]  OFS_OLEN   = 5'h0c;
	localparam logic [4:0]  OFS_ODLO   = 5'h10;
	localparam logic [4:0]  OFS_ODHI   = 5'h14;
	// object_control_reg fields
	localparam int CB_VALID = 0;
	localparam int CB_SEL   = 1;
	localparam int CB_RECEIVE_ALLOW  = 2;
	localparam int CB_UPD   = 3;
	localparam int CB_NEW   = 4;
	localparam int CB_LOST  = 5;
	localparam int CB_RXP   = 6;
	localparam int CB_TXP   = 7;
	localparam int CB_RXIE  = 8;
	localparam int CB_TXIE  = 9;
	// pointer register fields
	localparam int PF_RXL = 0;
	localparam int PF_TXL = 4;
	localparam int PF_POS = 8;
	// fold select encodings
	localparam logic [1:0] FOLD_NONE = 2'h0;
	localparam logic [1:0] FOLD_NODE = 2'h2;
	localparam logic [31:0] PND_RST  = 32'h00000000;
	localparam logic [5:0]  IDX_NONE = 6'h20;

	typedef struct packed {
		logic          ide;
		logic          remote;
		logic [3:0]    dlc;
		logic [ID_W-1:0] id;
		logic [63:0]   data;
	} canmp_frame_t;

	typedef enum logic [1:0] {
		CANMP_IDLE,
		CANMP_STORE,
		CANMP_FLAGS
	} canmp_state_t;
endpackage : canmp_pkg

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import canmp_pkg::*;
	logic                REF_CLK, RST_N, HSEL, HWRITE, ACC_WIN, RX_DONE, TX_DONE;
	logic [31:0]         HADDR, HWDATA, HRDATA, q;
	logic [1:0]          HTRANS;
	logic [2:0]          HSIZE, ACC_NODE, RX_NODE, TX_NODE;
	logic [7:0]          ACC_OBJ, RX_OBJ, TX_OBJ, IRQ_LINE, irq_seen;
	localparam int       N_OBJ_TB = 4;
	logic [N_OBJ_TB-1:0] RX_ALLOWED;
	logic                HREADYOUT, HRESP, pulse_tx, pulse_rx;
	wire logic           HREADY;
	canmp_frame_t        RX_FRAME;
	int                  err_total, checks, i;
	localparam logic [11:0] O1 = OBJ_BASE + OBJ_STRIDE;
	logic [1:0]          fmode [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
	logic [11:0]         freg  [4] = '{12'h01c, 12'h008, 12'h004, 12'h004};
	logic [31:0]         fbit  [4] = '{32'h8, 32'h8, 32'h80000, 32'h80000};
	assign HREADY = HREADYOUT;
	canmp_top #(.N_OBJ(N_OBJ_TB)) u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .ACC_WIN(ACC_WIN), .ACC_OBJ(ACC_OBJ), .ACC_NODE(ACC_NODE),
		.RX_ALLOWED(RX_ALLOWED), .RX_DONE(RX_DONE), .RX_OBJ(RX_OBJ), .RX_NODE(RX_NODE), .RX_FRAME(RX_FRAME),
		.TX_DONE(TX_DONE), .TX_OBJ(TX_OBJ), .TX_NODE(TX_NODE), .IRQ_LINE(IRQ_LINE));
	initial begin
		REF_CLK = 1'b0;
		forever #25 REF_CLK = ~REF_CLK;
	end
	always @(negedge REF_CLK) irq_seen <= irq_seen | IRQ_LINE;
	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task finish_test;
		if (err_total == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// answer arrives when hready seen high; bounded so a stuck slave ends the run
	task wait_rdy;
		int n;
		n = 0;
		@(posedge REF_CLK);
		while (HREADYOUT !== 1'b1) begin
			n++;
			if (n > 100) begin
				err_total++;
				$display("ERROR %0t bus timeout", $time);
				finish_test();
			end
			@(posedge REF_CLK);
		end
	endtask
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HADDR <= {20'h0, a};
		RX_DONE <= pulse_rx;
		wait_rdy();
		HTRANS <= 2'h0;
		HWDATA <= d;
		RX_DONE <= 1'b0;
		TX_DONE <= pulse_tx;
		wait_rdy();
		q = HRDATA;
		HSEL <= 1'b0;
		TX_DONE <= 1'b0;
		@(posedge REF_CLK);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task pulse_evt(input int which);
		if (which == 0) TX_DONE <= 1'b1;
		else if (which == 1) ACC_WIN <= 1'b1;
		else RX_DONE <= 1'b1;
		@(posedge REF_CLK);
		{TX_DONE, ACC_WIN, RX_DONE} <= 3'h0;
		repeat (5) @(posedge REF_CLK);
	endtask
	task set_frame(input logic rem, input logic [31:0] lo);
		RX_FRAME <= '{1'b1, rem, 4'h8, 29'h0abcdef1, {32'h11223344, lo}};
		@(posedge REF_CLK);
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task sc_reset;
		rdchk(PND_BASE, PND_RST);
		rdchk(IDX_BASE, {26'h0, IDX_NONE});
		chk({24'h0, IRQ_LINE}, 32'h0);
		wr(12'h0f0, 32'hffffffff);
		rdchk(12'h0f0, 32'h0);
	endtask
	task sc_tx;
		wr(OBJ_BASE + 12'h4, 32'h0520);
		wr(OBJ_BASE, 32'h1);
		irq_seen = 8'h0;
		pulse_evt(0);
		chk({24'h0, irq_seen}, 32'h0);
		rdchk(OBJ_BASE, 32'h81);
		rdchk(PND_BASE, 32'h0);
		wr(OBJ_BASE, 32'h201);
		irq_seen = 8'h0;
		pulse_evt(0);
		chk({24'h0, irq_seen}, 32'h4);
		rdchk(PND_BASE, 32'h20);
		rdchk(IDX_BASE, 32'h5);
		// clear all in the same cycle that hardware sets bit 6
		wr(OBJ_BASE + 12'h4, 32'h0620);
		pulse_tx = 1'b1;
		wr(PND_BASE, 32'h0);
		pulse_tx = 1'b0;
		repeat (4) @(posedge REF_CLK);
		rdchk(PND_BASE, 32'h40);
		rdchk(IDX_BASE, 32'h6);
	endtask
	task sc_rx;
		wr(O1 + 12'h4, 32'he305);
		wr(O1, 32'h105);
		chk({28'h0, RX_ALLOWED}, 32'h2);
		set_frame(1'b0, 32'ha5a5a5a5);
		irq_seen = 8'h0;
		pulse_evt(1);
		pulse_evt(2);
		chk({24'h0, irq_seen}, 32'h20);
		rdchk(O1, 32'h155);
		rdchk(O1 + 12'h8, {2'h0, 1'b1, 29'h0abcdef1});
		rdchk(O1 + 12'hc, 32'h8);
		rdchk(O1 + 12'h10, 32'ha5a5a5a5);
		rdchk(O1 + 12'h14, 32'h11223344);
		rdchk(PND_BASE + 12'h1c, 32'h8);
		rdchk(IDX_BASE + 12'h1c, 32'h3);
		set_frame(1'b1, 32'h5a5a5a5a);
		pulse_evt(1);
		pulse_evt(2);
		rdchk(O1, 32'h175);
		rdchk(O1 + 12'h10, 32'ha5a5a5a5);
	endtask
	task sc_gates;
		wr(O1, 32'h105);
		set_frame(1'b0, 32'h01020304);
		pulse_evt(1);
		wr(O1, 32'h103);
		chk({28'h0, RX_ALLOWED}, 32'h0);
		pulse_evt(2);
		rdchk(O1 + 12'h10, 32'h01020304);
		rdchk(O1, 32'h151);
		wr(O1, 32'h105);
		set_frame(1'b0, 32'hdeadbeef);
		pulse_evt(2);
		rdchk(O1, 32'h105);
		// valid dropped one cycle into the store sequence
		wr(O1, 32'h107);
		pulse_rx = 1'b1;
		wr(O1, 32'h106);
		pulse_rx = 1'b0;
		repeat (4) @(posedge REF_CLK);
		rdchk(O1, 32'h106);
		rdchk(O1 + 12'h10, 32'h01020304);
		wr(O1, 32'h106);
		pulse_evt(2);
		rdchk(O1 + 12'h10, 32'h01020304);
	endtask
	task sc_fold;
		RX_NODE <= 3'h3;
		for (i = 0; i < 4; i++) begin
			wr(O1, 32'h105);
			wr(PND_BASE + freg[i], 32'h0);
			wr(CTRL_REG, {30'h0, fmode[i]});
			pulse_evt(1);
			pulse_evt(2);
			rdchk(PND_BASE + freg[i], fbit[i]);
		end
	endtask
	initial begin
		{HSEL, HWRITE, ACC_WIN, RX_DONE, TX_DONE, pulse_tx, pulse_rx, RST_N} = 8'h0;
		{HADDR, HWDATA, HTRANS, ACC_NODE, RX_NODE, TX_NODE} = '0;
		{ACC_OBJ, RX_OBJ, TX_OBJ, irq_seen} = {8'h1, 8'h1, 8'h0, 8'h0};
		HSIZE = 3'h2;
		RX_FRAME = '0;
		err_total = 0;
		checks = 0;
		repeat (6) @(posedge REF_CLK);
		RST_N <= 1'b1;
		@(posedge REF_CLK);
		sc_reset();
		sc_tx();
		sc_rx();
		sc_gates();
		sc_fold();
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
